// *** design/pvp_radio.sv ***
/*
  radio end of the voice port: makes bit clock and frame sync, shifts
  downlink words out and captures uplink words.
  assumes a 100 MHz ref_clk and a host end that keeps the shared timing.
*/
`timescale 1ns/1ps
`default_nettype none
module pvp_radio
  import pvp_pkg::*;
(
  input wire logic ref_clk,                          // 100 MHz system clock
  input wire logic rst_b,                            // async reset, active low
  pvp_if.radio port,                                 // voice port wires
  input wire pvp_pkg::pvp_sample_t dl_sample,        // sample to send next frame
  input wire logic digital_voice_en,                 // digital path selected
  output logic dl_sample_taken,                      // pulse: dl_sample latched
  output pvp_pkg::pvp_sample_t ul_sample,            // last uplink sample
  output logic ul_valid,                             // pulse: ul_sample updated
  output logic analog_path_en                        // analog stages in use
);
  import pvp_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  // the first frame after reset runs with sync held low, so the host
  // never locks onto a word whose first bit went out unframed
  typedef enum logic [1:0] {
    PVP_PH_PRIME = 2'b00,                            // first frame, no sync
    PVP_PH_RUN = 2'b01                               // framed words
  } pvp_phase_e;

  typedef struct packed {
    pvp_phase_e phase;
    logic [CNT_W-1:0] div;
    logic bclk;
    logic [BIT_W-1:0] bitn;
    logic sync;
    pvp_word_t dl_sh;
    pvp_word_t ul_sh;
    logic dl_out;
    logic taken;
    pvp_sample_t ul_word;
    logic ul_v;
    logic uld_s1;
    logic uld_s2;
  } pvp_radio_s;

  pvp_radio_s r;
  pvp_radio_s next_r;

  // 390 cycles per phase: 3.9 us, above the 3.8 us floor
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(BCLK_HALF_CYC - 1);
  localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(BITS_PER_FRAME - 1);
  localparam logic [BIT_W-1:0] SYNC_END = BIT_W'(SYNC_HIGH_BITS);

  always_comb
  begin
    logic rise;
    logic fall;
    logic last_bit;
    logic [BIT_W-1:0] bit_after;
    pvp_word_t ul_next;
    next_r = r;
    rise = 1'b0;
    fall = 1'b0;
    last_bit = (r.bitn == BIT_LAST);
    bit_after = r.bitn + BIT_W'(1);
    ul_next = {r.ul_sh[WORD_W-2:0], r.uld_s2};
    next_r.taken = 1'b0;
    next_r.ul_v = 1'b0;
    // ************************************************************
    // uplink pin synchroniser
    // ************************************************************
    next_r.uld_s1 = port.voice_uplink_data;
    next_r.uld_s2 = r.uld_s1;
    // ************************************************************
    // bit clock divider
    // ************************************************************
    // a plain divider keeps both phases equal; the frame comes out at
    // 124.8 us instead of 125 us, the price of whole-cycle phases
    if (r.div == HALF_LAST)
    begin
      next_r.div = '0;
      next_r.bclk = ~r.bclk;
      rise = ~r.bclk;
      fall = r.bclk;
    end
    else
    begin
      next_r.div = r.div + CNT_W'(1);
    end
    // ************************************************************
    // downlink shifter
    // ************************************************************
    if (rise)
    begin
      // bit 0 of a frame goes out on the first rise after sync goes high
      if (r.bitn == '0)
      begin
        next_r.dl_sh = {dl_sample, {SAMPLE_LSB{1'b0}}};
        next_r.dl_out = dl_sample[SAMPLE_W-1];
        next_r.taken = 1'b1;
      end
      else
      begin
        next_r.dl_out = r.dl_sh[WORD_W-1-r.bitn];
      end
    end
    // ************************************************************
    // uplink shifter
    // ************************************************************
    if (fall)
    begin
      // uplink bit for the current period, same slot as downlink
      next_r.ul_sh = ul_next;
      if (last_bit)
      begin
        next_r.ul_word = ul_next[WORD_W-1 -: SAMPLE_W];
        next_r.ul_v = 1'b1;
      end
    end
    // ************************************************************
    // frame counter and sync
    // ************************************************************
    if (fall)
    begin
      next_r.bitn = bit_after;                       // wraps every 16
      // sync moves just after the fall, so only while the clock is low
      case (r.phase)
        PVP_PH_PRIME:
        begin
          // sync first rises at the end of the priming frame
          next_r.sync = last_bit;
          if (last_bit)
          begin
            next_r.phase = PVP_PH_RUN;
          end
        end
        PVP_PH_RUN:
        begin
          next_r.sync = (bit_after < SYNC_END);
        end
        default:
        begin
          next_r.phase = PVP_PH_PRIME;
          next_r.sync = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // link wires, all straight from flops so the host sees clean levels
  assign port.voice_bit_clock = r.bclk;
  assign port.voice_frame_sync = r.sync;
  assign port.voice_downlink_data = r.dl_out;

  // one-cycle pulse in the cycle after dl_sample was copied
  assign dl_sample_taken = r.taken;

  // sample holds until the next word ends; valid marks the update
  assign ul_sample = r.ul_word;
  assign ul_valid = r.ul_v;

  // the analog stages are only a flag here; no analog audio passes this block
  assign analog_path_en = ~digital_voice_en;
endmodule : pvp_radio
`default_nettype wire

// *** pkg/pvp_pkg.sv ***
/*
  shared constants and types for the synchronous voice port.
  assumes a 100 MHz ref_clk on both ends of the link.
*/
`default_nettype none
package pvp_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_PS = 10000;
  localparam int BCLK_HALF_NS = 3900;       // nominal bit clock phase
  localparam int BCLK_HALF_MIN_NS = 3800;   // shortest allowed phase
  localparam int BCLK_HALF_CYC = (BCLK_HALF_NS * 1000) / CLK_PERIOD_PS;
  localparam int BITS_PER_FRAME = 16;       // 16 bit clock periods per 124.8 us frame
  localparam int SYNC_HIGH_BITS = 8;        // sync high for half the frame
  // ************************************************************
  // word layout
  // ************************************************************
  localparam int WORD_W = 16;
  localparam int SAMPLE_W = 13;
  localparam int SAMPLE_LSB = 3;
  localparam int CNT_W = 10;
  localparam int BIT_W = 4;
  typedef logic [WORD_W-1:0] pvp_word_t;
  typedef logic [SAMPLE_W-1:0] pvp_sample_t;
endpackage : pvp_pkg
`default_nettype wire

// *** pkg/pvp_if.sv ***
/*
  the four wires of the voice port between the radio end and the host end.
  assumes both ends share nothing but these wires.
*/
`timescale 1ns/1ps
`default_nettype none
interface pvp_if;
  logic voice_bit_clock;
  logic voice_frame_sync;
  logic voice_downlink_data;
  logic voice_uplink_data;
  modport radio (
    output voice_bit_clock,
    output voice_frame_sync,
    output voice_downlink_data,
    input voice_uplink_data
  );
  modport host (
    input voice_bit_clock,
    input voice_frame_sync,
    input voice_downlink_data,
    output voice_uplink_data
  );
endinterface : pvp_if
`default_nettype wire

// *** design/pvp_host.sv ***
/*
  host end of the voice port: follows the radio's bit clock and sync,
  shifts uplink words out and captures downlink words.
  assumes a 100 MHz ref_clk much faster than the 128 kHz bit clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pvp_host
  import pvp_pkg::*;
(
  input wire logic ref_clk,                          // 100 MHz system clock
  input wire logic rst_b,                            // async reset, active low
  pvp_if.host port,                                  // voice port wires
  input wire pvp_pkg::pvp_sample_t ul_sample,        // sample to send next frame
  output logic ul_sample_taken,                      // pulse: ul_sample latched
  output pvp_pkg::pvp_sample_t dl_sample,            // last downlink sample
  output logic dl_valid                              // pulse: dl_sample updated
);
  import pvp_pkg::*;

  typedef struct packed {
    logic [2:0] clk_s;
    logic [1:0] sync_s;
    logic [1:0] dld_s;
    logic [BIT_W-1:0] bitn;
    logic armed;
    pvp_word_t ul_sh;
    pvp_word_t dl_sh;
    logic ul_out;
    logic taken;
    pvp_sample_t dl_word;
    logic dl_v;
  } pvp_host_s;

  pvp_host_s r;
  pvp_host_s next_r;

  always_comb
  begin
    logic rise;
    logic fall;
    pvp_word_t w;
    next_r = r;
    next_r.taken = 1'b0;
    next_r.dl_v = 1'b0;
    // pins pass two flops; edges are found between stages two and three
    next_r.clk_s = {r.clk_s[1:0], port.voice_bit_clock};
    next_r.sync_s = {r.sync_s[0], port.voice_frame_sync};
    next_r.dld_s = {r.dld_s[0], port.voice_downlink_data};
    rise = r.clk_s[1] & ~r.clk_s[2];
    fall = ~r.clk_s[1] & r.clk_s[2];
    w = {r.dl_sh[WORD_W-2:0], r.dld_s[1]};
    if (rise)
    begin
      // a rise with sync high while idle starts the frame
      if (r.sync_s[1] && !r.armed)
      begin
        next_r.armed = 1'b1;
        next_r.bitn = '0;
        next_r.ul_sh = {ul_sample, {SAMPLE_LSB{1'b0}}};
        next_r.ul_out = ul_sample[SAMPLE_W-1];
        next_r.taken = 1'b1;
      end
      else if (r.armed)
      begin
        next_r.ul_out = r.ul_sh[WORD_W-1-r.bitn];
      end
    end
    if (fall && r.armed)
    begin
      // uplink bit held from rise to rise, stable across the radio's fall
      next_r.dl_sh = w;
      if (r.bitn == BIT_W'(BITS_PER_FRAME - 1))
      begin
        // arithmetic shift right by three keeps the sign
        next_r.dl_word = w[WORD_W-1 -: SAMPLE_W];
        next_r.dl_v = 1'b1;
        next_r.armed = 1'b0;
      end
      next_r.bitn = r.bitn + BIT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign port.voice_uplink_data = r.ul_out;
  assign ul_sample_taken = r.taken;
  assign dl_sample = r.dl_word;
  assign dl_valid = r.dl_v;
endmodule : pvp_host
`default_nettype wire

// *** dv/pvp_link_asserts.sv ***
/*
  timing checks on the four voice port wires.
  assumes a 100 MHz ref_clk and the radio end as bit clock source.
*/
`timescale 1ns/1ps
`default_nettype none
module pvp_link_asserts (
  input wire logic ref_clk,             // system clock
  input wire logic rst_b,               // async reset, active low
  input wire logic voice_bit_clock,     // bit clock
  input wire logic voice_frame_sync,    // frame sync
  input wire logic voice_downlink_data, // downlink bits
  input wire logic voice_uplink_data    // uplink bits
);
  logic [9:0] cnt;
  logic [12:0] scnt;
  logic [4:0] rcnt;
  logic seen;
  // ****************
  // phase counters
  // ****************
  // the frame before the first sync rise is unframed, so length checks wait for it
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= 10'h0;
      scnt <= 13'h0;
      rcnt <= 5'h0;
      seen <= 1'b0;
    end
    else
    begin
      cnt <= $changed(voice_bit_clock) ? 10'h0 : cnt + 10'h1;
      scnt <= $changed(voice_frame_sync) ? 13'h0 : scnt + 13'h1;
      rcnt <= $rose(voice_frame_sync) ? 5'h0 : rcnt + 5'($rose(voice_bit_clock));
      seen <= seen | $rose(voice_frame_sync);
    end
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  property p_bclk_min;
    $changed(voice_bit_clock) |-> cnt >= 10'h17b;
  endproperty
  a_bclk_min: assert property (p_bclk_min)
    else $error("bit clock phase too short");
  property p_bclk_max;
    cnt <= 10'h186;
  endproperty
  a_bclk_max: assert property (p_bclk_max)
    else $error("bit clock phase too long");
  property p_sync_low;
    $changed(voice_frame_sync) |-> !voice_bit_clock;
  endproperty
  a_sync_low: assert property (p_sync_low)
    else $error("sync moved while bit clock high");
  property p_sync_hold;
    $changed(voice_frame_sync) |=> !voice_bit_clock [*8];
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("sync moved too near a bit clock rise");
  property p_dl_edge;
    $changed(voice_downlink_data) |->
      voice_bit_clock && ($rose(voice_bit_clock) || cnt <= 10'h4);
  endproperty
  a_dl_edge: assert property (p_dl_edge)
    else $error("downlink bit moved away from a rise");
  property p_ul_edge;
    $changed(voice_uplink_data) |-> voice_bit_clock && cnt <= 10'h8;
  endproperty
  a_ul_edge: assert property (p_ul_edge)
    else $error("uplink bit moved near a fall");
  property p_sync_len;
    $changed(voice_frame_sync) && seen |-> scnt == 13'h185f;
  endproperty
  a_sync_len: assert property (p_sync_len)
    else $error("sync phase length wrong");
  property p_frame_bits;
    $rose(voice_frame_sync) && seen |-> rcnt == 5'h10;
  endproperty
  a_frame_bits: assert property (p_frame_bits)
    else $error("frame not sixteen bit periods");
endmodule : pvp_link_asserts
`default_nettype wire

// *** dv/pcm_voice_port_tb.sv ***
/*
  testbench joining radio and host ends across one voice port.
  assumes the pvp package, interface and both design ends are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module pcm_voice_port_tb;
  import pvp_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic dve = 1'b1;
  pvp_sample_t dl_drv = 13'h1000;
  pvp_sample_t ul_drv = 13'h0fff;
  pvp_sample_t r_ul, h_dl, last_dl, last_ul;
  logic dl_tk, ul_tk, r_ulv, h_dlv, ana, pb, ps;
  logic armed = 1'b0;
  pvp_word_t wd, wu;
  int err_total = 0;
  int n_tests = 0;
  pvp_sample_t tab [5] = '{13'h1000, 13'h0fff, 13'h0000, 13'h1fff, 13'h0aaa};
  pvp_if link ();
  pvp_radio pvp_radio_inst (.ref_clk(ref_clk), .rst_b(rst_b), .port(link),
    .dl_sample(dl_drv), .digital_voice_en(dve), .dl_sample_taken(dl_tk),
    .ul_sample(r_ul), .ul_valid(r_ulv), .analog_path_en(ana));
  pvp_host pvp_host_inst (.ref_clk(ref_clk), .rst_b(rst_b), .port(link),
    .ul_sample(ul_drv), .ul_sample_taken(ul_tk), .dl_sample(h_dl), .dl_valid(h_dlv));
  pvp_link_asserts pvp_link_asserts_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .voice_bit_clock(link.voice_bit_clock), .voice_frame_sync(link.voice_frame_sync),
    .voice_downlink_data(link.voice_downlink_data),
    .voice_uplink_data(link.voice_uplink_data));
  task chk(input bit ok, input string msg);
    n_tests++;
    if (!ok)
    begin
      err_total++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : chk
  task conclude;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  task wait_dlv;
    int k;
    @(posedge ref_clk);
    #1;
    // the first word needs the unframed priming frame plus one more
    for (k = 0; k < 30000 && h_dlv !== 1'b1; k++)
    begin
      @(posedge ref_clk);
      #1;
    end
    chk(k < 30000, "no downlink word arrived");
  endtask : wait_dlv
  // ****************
  // wire monitor
  // ****************
  // words are gathered at bit clock falls; the first frame has no sync, so none is expected
  // sampled on the falling edge so design outputs have settled
  always @(negedge ref_clk)
  begin
    if (pb && link.voice_bit_clock === 1'b0)
    begin
      wd = {wd[14:0], link.voice_downlink_data};
      wu = {wu[14:0], link.voice_uplink_data};
    end
    if (ps === 1'b0 && link.voice_frame_sync === 1'b1 && armed)
    begin
      chk(wd === {last_dl, 3'h0}, "downlink word on wire");
      chk(wu === {last_ul, 3'h0}, "uplink word on wire");
    end
    if (ul_tk === 1'b1)
    begin
      last_ul = ul_drv;
      armed = 1'b1;
    end
    if (dl_tk === 1'b1 && link.voice_frame_sync === 1'b1)
      last_dl = dl_drv;
    if (h_dlv === 1'b1)
      chk(h_dl === last_dl, "host downlink sample");
    if (r_ulv === 1'b1 && armed)
      chk(r_ul === last_ul, "radio uplink sample");
    pb = link.voice_bit_clock;
    ps = link.voice_frame_sync;
  end
  initial
    forever #5 ref_clk = ~ref_clk;
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    $display("Error at %0t: run hung", $time);
    conclude;
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    chk(link.voice_bit_clock === 1'b0 && link.voice_frame_sync === 1'b0, "reset levels");
    #1 rst_b = 1'b1;
    chk(ana === 1'b0, "analog path with digital voice");
    dve = 1'b0;
    #1 chk(ana === 1'b1, "analog path without digital voice");
    dve = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      dl_drv = tab[i];
      ul_drv = ~tab[i];
      wait_dlv;
    end
    conclude;
  end
endmodule : pcm_voice_port_tb
`default_nettype wire
